// ---- rtl/fcwd_pkg.sv ----
// shared constants and types for the fieldbus command word decoder
package fcwd_pkg;

    // command word width
    localparam int unsigned CMD_WIDTH = 32;

    // lower-word bit positions
    localparam int unsigned BIT_STOP       = 0;
    localparam int unsigned BIT_START      = 1;
    localparam int unsigned BIT_REVERSE    = 2;
    localparam int unsigned BIT_FAULT_CLR  = 4;
    localparam int unsigned BIT_EXT_SELECT = 5;

    // bit positions from 6 upward, spanning lower and upper word
    localparam int unsigned BIT_RUN_BLOCK      = 6;
    localparam int unsigned BIT_RAMPED_HALT    = 7;
    localparam int unsigned BIT_URGENT_HALT    = 8;
    localparam int unsigned BIT_FREEWHEEL_HALT = 9;
    localparam int unsigned BIT_SECOND_RAMP    = 10;
    localparam int unsigned BIT_RAMP_OUT_ZERO  = 11;
    localparam int unsigned BIT_RAMP_FREEZE    = 12;
    localparam int unsigned BIT_RAMP_IN_ZERO   = 13;
    localparam int unsigned BIT_LOCAL_LOCK     = 14;
    localparam int unsigned BIT_SECOND_TORQUE  = 15;
    localparam int unsigned BIT_TAKE_COMMAND   = 16;
    localparam int unsigned BIT_TAKE_SETPOINT  = 17;
    localparam int unsigned BIT_RUN_BLOCK_ALT  = 18;
    localparam int unsigned BIT_APP_LO         = 22;
    localparam int unsigned APP_FLAG_COUNT     = 4;

    // bits the block stores; reserved bits 3, 19..21, 26..31 drop out
    localparam logic [CMD_WIDTH-1:0] CMD_KEEP_MASK = 32'h03C7_FFF7;

    // command word value after reset
    localparam logic [CMD_WIDTH-1:0] CMD_RESET_VALUE = 32'h0000_0000;

    // selected stop behaviour
    typedef enum logic [1:0] {
        FCWD_HALT_RAMPED,
        FCWD_HALT_URGENT,
        FCWD_HALT_FREEWHEEL
    } fcwd_halt_type;

endpackage

// ---- rtl/fcwd_word_reg.sv ----
// holding register for the fieldbus command word
`timescale 1ns/100ps

module fcwd_word_reg (
    // clock and reset
    input  wire logic                            mclk,
    input  wire logic                            rstn,
    // write side
    input  wire logic                            wr_stb,
    input  wire logic [fcwd_pkg::CMD_WIDTH-1:0]  wr_data,
    // held word and write marker
    output logic      [fcwd_pkg::CMD_WIDTH-1:0]  word_q,
    output logic                                 wr_seen_q
);
    import fcwd_pkg::*;

    logic [CMD_WIDTH-1:0] word_d;   // next held word
    logic                 seen_d;   // next write marker

    ////////////////////////////////////////////////////////////////////////
    // next value: word taken as written, reserved bits masked off
    always_comb begin
        word_d = word_q;
        seen_d = 1'b0;
        if (wr_stb) begin
            word_d = wr_data & CMD_KEEP_MASK;
            seen_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            word_q    <= CMD_RESET_VALUE;
            wr_seen_q <= 1'b0;
        end else begin
            word_q    <= word_d;
            wr_seen_q <= seen_d;
        end
    end

endmodule

// ---- rtl/fcwd_decode.sv ----
// decoder of the fieldbus command word into drive control levels
`timescale 1ns/100ps

module fcwd_decode (
    // clock and reset
    input  wire logic                               mclk,
    input  wire logic                               rstn,
    // command word write from the fieldbus interface
    input  wire logic                               cmd_wr,
    input  wire logic [fcwd_pkg::CMD_WIDTH-1:0]     cmd_data,
    // configuration from drive parameters
    input  wire logic                               run_enable_from_bus,
    input  wire logic                               run_enable_local,
    input  wire fcwd_pkg::fcwd_halt_type            param_halt_mode,
    // stop and start controls
    output logic                                    stop_request,
    output fcwd_pkg::fcwd_halt_type                 halt_mode,
    output logic                                    ramped_halt_select,
    output logic                                    urgent_halt_select,
    output logic                                    freewheel_halt_select,
    output logic                                    start_request,
    output logic                                    reverse_request,
    output logic                                    ext_location_two,
    output logic                                    fault_clear_pulse,
    output logic                                    run_enable,
    // ramp generator controls
    output logic                                    ramp_out_zero,
    output logic                                    ramp_freeze,
    output logic                                    ramp_in_zero,
    // control location takeover
    output logic                                    bus_takeover_command,
    output logic                                    bus_takeover_setpoint,
    // application flags
    output logic [fcwd_pkg::APP_FLAG_COUNT-1:0]     app_flags
);
    import fcwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // held word
    logic [CMD_WIDTH-1:0] word_q;      // latest accepted command word
    logic                 wr_seen_q;   // one cycle after each write

    // masks reserved bits on entry and marks each write
    fcwd_word_reg u_word (
        .mclk      (mclk),
        .rstn      (rstn),
        .wr_stb    (cmd_wr),
        .wr_data   (cmd_data),
        .word_q    (word_q),
        .wr_seen_q (wr_seen_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // stop mode choice; coast outranks urgent outranks ramped when
    // several request bits are set, the least energetic stop wins
    function automatic fcwd_halt_type pick_halt(
        input logic [CMD_WIDTH-1:0] w,
        input fcwd_halt_type        fallback
    );
        fcwd_halt_type m;
        // fallback stands unless a request bit is set
        m = fallback;
        if (w[BIT_FREEWHEEL_HALT]) begin
            m = FCWD_HALT_FREEWHEEL;
        end else if (w[BIT_URGENT_HALT]) begin
            m = FCWD_HALT_URGENT;
        end else if (w[BIT_RAMPED_HALT]) begin
            m = FCWD_HALT_RAMPED;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // fault clear edge tracking
    logic fclr_prev_q;   // bit 4 as of the previous accepted word
    logic fclr_prev_d;   // next value
    logic fclr_pulse_q;  // registered clear pulse
    logic fclr_pulse_d;  // next value

    // edge only counted once per write, so a steady 1 rewritten is quiet
    always_comb begin
        fclr_prev_d  = fclr_prev_q;
        fclr_pulse_d = 1'b0;
        if (wr_seen_q) begin
            fclr_prev_d  = word_q[BIT_FAULT_CLR];
            fclr_pulse_d = word_q[BIT_FAULT_CLR] & ~fclr_prev_q;
        end
    end

    // edge history and pulse registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // reset: no history, no pulse
            fclr_prev_q  <= 1'b0;
            fclr_pulse_q <= 1'b0;
        end else begin
            // run: register edge history and pulse
            fclr_prev_q  <= fclr_prev_d;
            fclr_pulse_q <= fclr_pulse_d;
        end
    end

    // pulse leaves straight from its flip-flop
    assign fault_clear_pulse = fclr_pulse_q;

    ////////////////////////////////////////////////////////////////////////
    // decoded control levels
    logic                      stop_q,   stop_d;    // stop request
    fcwd_halt_type             mode_q,   mode_d;    // effective stop mode
    logic                      rhs_q,    rhs_d;     // ramped stop bit
    logic                      uhs_q,    uhs_d;     // urgent stop bit
    logic                      fhs_q,    fhs_d;     // coast stop bit
    logic                      start_q,  start_d;   // start request
    logic                      rev_q,    rev_d;     // reverse request
    logic                      ext_q,    ext_d;     // location two select
    logic                      run_q,    run_d;     // run enable
    logic                      roz_q,    roz_d;     // ramp output zero
    logic                      rfz_q,    rfz_d;     // ramp hold
    logic                      riz_q,    riz_d;     // ramp input zero
    logic                      tcmd_q,   tcmd_d;    // command takeover
    logic                      tsp_q,    tsp_d;     // setpoint takeover
    logic [APP_FLAG_COUNT-1:0] app_q,    app_d;     // application flags

    // next values from the held word; run enable and the fallback stop mode can also come from the configuration inputs
    always_comb begin
        stop_d  = word_q[BIT_STOP];
        mode_d  = pick_halt(word_q, param_halt_mode);
        rhs_d   = word_q[BIT_RAMPED_HALT];
        uhs_d   = word_q[BIT_URGENT_HALT];
        fhs_d   = word_q[BIT_FREEWHEEL_HALT];
        // lower word bits pass through as levels
        start_d = word_q[BIT_START];
        rev_d   = word_q[BIT_REVERSE];
        ext_d   = word_q[BIT_EXT_SELECT];
        // bus-sourced run enable follows bit 6 inverted
        if (run_enable_from_bus) begin
            run_d = ~word_q[BIT_RUN_BLOCK];
        end else begin
            run_d = run_enable_local;
        end
        roz_d   = word_q[BIT_RAMP_OUT_ZERO];
        rfz_d   = word_q[BIT_RAMP_FREEZE];
        riz_d   = word_q[BIT_RAMP_IN_ZERO];
        tcmd_d  = word_q[BIT_TAKE_COMMAND];
        tsp_d   = word_q[BIT_TAKE_SETPOINT];
        app_d   = word_q[BIT_APP_LO +: APP_FLAG_COUNT];
        // bits 10, 14, 15, 18 are held but nothing reads them
    end

    // register the decoded levels
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // reset: all levels quiet, ramped stop mode
            stop_q  <= 1'b0;
            mode_q  <= FCWD_HALT_RAMPED;
            rhs_q   <= 1'b0;
            uhs_q   <= 1'b0;
            fhs_q   <= 1'b0;
            start_q <= 1'b0;
            rev_q   <= 1'b0;
            ext_q   <= 1'b0;
            run_q   <= 1'b0;
            roz_q   <= 1'b0;
            rfz_q   <= 1'b0;
            riz_q   <= 1'b0;
            tcmd_q  <= 1'b0;
            tsp_q   <= 1'b0;
            app_q   <= '0;
        end else begin
            // run: load the next values
            stop_q  <= stop_d;
            mode_q  <= mode_d;
            rhs_q   <= rhs_d;
            uhs_q   <= uhs_d;
            fhs_q   <= fhs_d;
            start_q <= start_d;
            rev_q   <= rev_d;
            ext_q   <= ext_d;
            run_q   <= run_d;
            roz_q   <= roz_d;
            rfz_q   <= rfz_d;
            riz_q   <= riz_d;
            tcmd_q  <= tcmd_d;
            tsp_q   <= tsp_d;
            app_q   <= app_d;
        end
    end

    // latency: a write taken on one edge updates the held word there, and
    // the decoded levels follow one edge later; the fault clear pulse
    // rises on that same later edge and lasts one cycle

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // each output is read straight from its flip-flop
    assign stop_request          = stop_q;
    assign halt_mode             = mode_q;
    assign ramped_halt_select    = rhs_q;
    assign urgent_halt_select    = uhs_q;
    assign freewheel_halt_select = fhs_q;
    assign start_request         = start_q;
    assign reverse_request       = rev_q;
    assign ext_location_two      = ext_q;
    assign run_enable            = run_q;
    assign ramp_out_zero         = roz_q;
    assign ramp_freeze           = rfz_q;
    assign ramp_in_zero          = riz_q;
    assign bus_takeover_command  = tcmd_q;
    assign bus_takeover_setpoint = tsp_q;
    assign app_flags             = app_q;

endmodule

// ---- tb/fcwd_decode_checker.sv ----
// assertion checker for the command word decoder ports
`timescale 1ns/100ps

module fcwd_decode_checker
    import fcwd_pkg::*;
(
    // clock, reset and write side
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_wr,
    input wire logic [fcwd_pkg::CMD_WIDTH-1:0] cmd_data,
    // configuration
    input wire logic run_enable_from_bus,
    input wire fcwd_pkg::fcwd_halt_type param_halt_mode,
    // decoded outputs
    input wire logic stop_request,
    input wire fcwd_pkg::fcwd_halt_type halt_mode,
    input wire logic ramped_halt_select,
    input wire logic urgent_halt_select,
    input wire logic freewheel_halt_select,
    input wire logic fault_clear_pulse,
    input wire logic run_enable,
    input wire logic ramp_out_zero,
    input wire logic ramp_freeze,
    input wire logic ramp_in_zero,
    input wire logic bus_takeover_command,
    input wire logic bus_takeover_setpoint,
    input wire logic [fcwd_pkg::APP_FLAG_COUNT-1:0] app_flags
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // levels follow the written word one edge after the write edge and are sampled at the second
    property p_run; (cmd_wr && run_enable_from_bus) ##1
        run_enable_from_bus [*2] |-> run_enable == !$past(cmd_data[6], 2);
    endproperty
    a_run: assert property (p_run) else $error("run enable wrong");
    property p_sel; cmd_wr |-> ##2 {freewheel_halt_select,
        urgent_halt_select, ramped_halt_select} == $past(cmd_data[9:7], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("stop select wrong");
    property p_dflt; cmd_wr && cmd_data[9:7] == 3'h0
        |-> ##2 halt_mode == $past(param_halt_mode, 1);
    endproperty
    a_dflt: assert property (p_dflt) else $error("stop mode wrong");
    property p_ramp; cmd_wr |-> ##2 {ramp_in_zero, ramp_freeze,
        ramp_out_zero} == $past(cmd_data[13:11], 2);
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("ramp wrong");
    property p_take; cmd_wr |-> ##2 {bus_takeover_setpoint,
        bus_takeover_command} == $past(cmd_data[17:16], 2);
    endproperty
    a_take: assert property (p_take)
        else $error("takeover wrong");
    property p_app; cmd_wr |-> ##2 app_flags == $past(cmd_data[25:22], 2);
    endproperty
    a_app: assert property (p_app) else $error("flags wrong");
    property p_stop; cmd_wr |-> ##2 stop_request == $past(cmd_data[0], 2);
    endproperty
    a_stop: assert property (p_stop) else $error("stop wrong");
    // one pulse, seen two edges after a write with bit 4 set
    property p_pulse; fault_clear_pulse |-> ($past(cmd_wr, 2) &&
        $past(cmd_data[4], 2)) ##1 !fault_clear_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse wrong");
    // without a recent write the stop, ramp and application flag levels stand
    property p_hold; !$past(cmd_wr, 2) |-> $stable({stop_request,
        ramp_out_zero, ramp_freeze, ramp_in_zero, app_flags});
    endproperty
    a_hold: assert property (p_hold) else $error("level moved");
endmodule

// ---- tb/fcwd_bus_master.sv ----
// fieldbus master model that writes the command word
`timescale 1ns/100ps

module fcwd_bus_master
    import fcwd_pkg::*;
(
    // clock
    input  wire logic                          mclk,
    // command word write
    output logic                               cmd_wr,
    output logic [fcwd_pkg::CMD_WIDTH-1:0]     cmd_data
);
    // reserved bits a well-behaved master keeps at zero
    localparam logic [CMD_WIDTH-1:0] RSV_MASK = 32'hFC380008;
    initial begin
        cmd_wr = 1'b0;
        cmd_data = 32'h0;
    end
    // hold one whole word across one edge; raw keeps reserved bits
    task automatic write_word(input logic [CMD_WIDTH-1:0] w,
                              input logic raw);
        cmd_wr = 1'b1;
        cmd_data = raw ? w : (w & ~RSV_MASK);
        @(negedge mclk);
    endtask
    // release; stale data shown inverted
    task automatic idle();
        cmd_wr = 1'b0;
        cmd_data = ~cmd_data;
    endtask
endmodule

// ---- tb/fcwd_decode_tb_top.sv ----
// self-checking testbench for the command word decoder
`timescale 1ns/100ps

module fcwd_decode_tb_top;
    import fcwd_pkg::*;
    // clock, reset and configuration
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic run_enable_from_bus = 1'b1;
    logic run_enable_local = 1'b0;
    fcwd_halt_type param_halt_mode = FCWD_HALT_RAMPED;
    // write side and decoded outputs
    logic cmd_wr;
    logic [CMD_WIDTH-1:0] cmd_data;
    logic stop_request, ramped_halt_select, urgent_halt_select;
    logic freewheel_halt_select, start_request, reverse_request;
    logic ext_location_two, fault_clear_pulse, run_enable;
    logic ramp_out_zero, ramp_freeze, ramp_in_zero;
    logic bus_takeover_command, bus_takeover_setpoint;
    fcwd_halt_type halt_mode;
    logic [APP_FLAG_COUNT-1:0] app_flags;
    logic [18:0] seen;
    int num_errors = 0;
    int tests_run = 0;
    // one bit per word, plus the stop priority pair and the four application flags together
    localparam logic [31:0] WORDS [14] = '{32'h1, 32'h2, 32'h4, 32'h20,
        32'h40, 32'h80, 32'h100, 32'h180, 32'h800, 32'h1000, 32'h2000,
        32'h10000, 32'h20000, 32'h3C00000};
    always #20 mclk = ~mclk;
    fcwd_bus_master master (.mclk, .cmd_wr, .cmd_data);
    fcwd_decode dut (.mclk, .rstn, .cmd_wr, .cmd_data, .run_enable_from_bus,
        .run_enable_local, .param_halt_mode, .stop_request, .halt_mode,
        .ramped_halt_select, .urgent_halt_select, .freewheel_halt_select,
        .start_request, .reverse_request, .ext_location_two,
        .fault_clear_pulse, .run_enable, .ramp_out_zero, .ramp_freeze,
        .ramp_in_zero, .bus_takeover_command, .bus_takeover_setpoint,
        .app_flags);
    assign seen = {stop_request, halt_mode, ramped_halt_select,
        urgent_halt_select, freewheel_halt_select, start_request,
        reverse_request, ext_location_two, run_enable, ramp_out_zero,
        ramp_freeze, ramp_in_zero, bus_takeover_command,
        bus_takeover_setpoint, app_flags};
    // expected outputs for a written word
    function automatic logic [18:0] expv(input logic [31:0] w);
        logic [1:0] hm;
        hm = w[9] ? 2'h2 : w[8] ? 2'h1 : w[7] ? 2'h0 : param_halt_mode;
        return {w[0], hm, w[7], w[8], w[9], w[1], w[2], w[5],
            run_enable_from_bus ? ~w[6] : run_enable_local,
            w[11], w[12], w[13], w[16], w[17], w[25:22]};
    endfunction
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write, then compare once levels have landed
    task automatic wr_chk(input logic [31:0] w, input logic raw);
        master.write_word(w, raw);
        master.idle();
        @(negedge mclk);
        check(seen, expv(w));
    endtask
    // count fault clear pulses after one write
    task automatic pulses(input logic [31:0] w, input int exp);
        int n;
        n = 0;
        master.write_word(w, 1'b1);
        master.idle();
        repeat (5) begin
            @(negedge mclk);
            if (fault_clear_pulse === 1'b1) n++;
        end
        check(19'(n), 19'(exp));
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        check(seen, 19'h0);
        rstn = 1'b1;
        foreach (WORDS[i]) begin
            wr_chk(WORDS[i], 1'b1);
        end
        wr_chk(32'hFC3CC408, 1'b1);
        wr_chk(32'hFFFFFFFF, 1'b0);
        master.write_word(32'h2001, 1'b1);
        master.write_word(32'h2000800, 1'b1);
        master.idle();
        check(seen, expv(32'h2001));
        @(negedge mclk);
        check(seen, expv(32'h2000800));
        for (int i = 0; i < 3; i++) begin
            param_halt_mode = fcwd_halt_type'(i);
            wr_chk(32'h1, 1'b1);
            wr_chk(32'h101, 1'b1);
        end
        run_enable_from_bus = 1'b0;
        for (int i = 0; i < 4; i++) begin
            run_enable_local = i[0];
            wr_chk(i[1] ? 32'h40 : 32'h0, 1'b1);
        end
        run_enable_from_bus = 1'b1;
        pulses(32'h10, 1);
        pulses(32'h10, 0);
        pulses(32'h0, 0);
        pulses(32'h10, 1);
        summarize();
    end
    // cut a hang short
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        summarize();
    end
endmodule

bind fcwd_decode fcwd_decode_checker u_chk (.mclk, .rstn, .cmd_wr, .cmd_data,
    .run_enable_from_bus, .param_halt_mode, .stop_request, .halt_mode,
    .ramped_halt_select, .urgent_halt_select, .freewheel_halt_select,
    .fault_clear_pulse, .run_enable, .ramp_out_zero, .ramp_freeze,
    .ramp_in_zero, .bus_takeover_command, .bus_takeover_setpoint, .app_flags);
